// File: pkg/parallel_io_pkg.sv
package parallel_io_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int REG_IDX_W = 6;
    localparam int BYTE_W = 8;
    localparam int NUM_BANKS = 2;

    // Register indices; byte address is four times the index
    localparam logic [REG_IDX_W-1:0] IDX_B1_PORT_A = 6'h00;
    localparam logic [REG_IDX_W-1:0] IDX_B1_PORT_B = 6'h01;
    localparam logic [REG_IDX_W-1:0] IDX_B1_PORT_C = 6'h02;
    localparam logic [REG_IDX_W-1:0] IDX_B1_DIR_CTRL = 6'h03;
    localparam logic [REG_IDX_W-1:0] IDX_B1_IRQ_SETUP = 6'h04;
    localparam logic [REG_IDX_W-1:0] IDX_IRQ_PENDING = 6'h05;
    localparam logic [REG_IDX_W-1:0] IDX_IRQ_MASK = 6'h06;
    localparam logic [REG_IDX_W-1:0] IDX_B2_PORT_A = 6'h08;
    localparam logic [REG_IDX_W-1:0] IDX_B2_PORT_B = 6'h09;
    localparam logic [REG_IDX_W-1:0] IDX_B2_PORT_C = 6'h0A;
    localparam logic [REG_IDX_W-1:0] IDX_B2_DIR_CTRL = 6'h0B;
    localparam logic [REG_IDX_W-1:0] IDX_B2_IRQ_SETUP = 6'h0C;

    ////////////////////////////////////////////////////////////////////////
    // Control word fields
    localparam int DIR_C_LO_BIT = 0;
    localparam int DIR_B_BIT = 1;
    localparam int DIR_C_HI_BIT = 3;
    localparam int DIR_A_BIT = 4;
    localparam int CMD_SELECT_BIT = 7;
    localparam int BSR_VALUE_BIT = 0;
    localparam int BSR_SEL_LSB = 1;
    localparam int BSR_SEL_MSB = 3;
    localparam int NIBBLE_W = 4;

    // Interrupt setup and pending fields
    localparam int IRQ_EN_BIT = 2;
    localparam int IRQ_SETUP_W = 3;
    localparam int IRQ_SRC_BIT = 0;
    localparam int PEND_BANK1_BIT = 0;
    localparam int PEND_BANK2_BIT = 4;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        IRQ_LOW_LEVEL = 2'b00,
        IRQ_HIGH_LEVEL = 2'b01,
        IRQ_FALL_EDGE = 2'b10,
        IRQ_RISE_EDGE = 2'b11
    } irq_mode_t;

    typedef enum logic [2:0] {
        LOC_PORT_A = 3'b000,
        LOC_PORT_B = 3'b001,
        LOC_PORT_C = 3'b010,
        LOC_DIR_CTRL = 3'b011,
        LOC_IRQ_SETUP = 3'b100,
        LOC_PENDING = 3'b101,
        LOC_MASK = 3'b110,
        LOC_NONE = 3'b111
    } reg_loc_t;

    typedef struct packed {
        logic [BYTE_W-1:0] c;
        logic [BYTE_W-1:0] b;
        logic [BYTE_W-1:0] a;
    } port_bytes_t;

    // One means input
    typedef struct packed {
        logic a;
        logic b;
        logic c_hi;
        logic c_lo;
    } dir_t;

    typedef struct packed {
        logic enable;
        irq_mode_t mode;
    } irq_setup_t;

    localparam dir_t DIR_RESET = 4'hF;
    localparam irq_setup_t IRQ_SETUP_RESET = 3'h0;
    localparam port_bytes_t OUT_RESET = 24'h000000;
    localparam port_bytes_t OE_RESET = 24'h000000;

endpackage

// File: design/irq_trigger.sv
`timescale 1ns/1ps

// Watches one source line and pulses when the chosen condition holds
module irq_trigger
    import parallel_io_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Setup and source
    input wire irq_setup_t setup,
    input wire logic source,
    // Result
    output logic event_out
);

    typedef struct packed {
        logic prev;
        logic event_hit;
    } trig_state_t;

    trig_state_t st_q;
    trig_state_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // Levels report every cycle; pending is sticky so that does no harm
    always_comb begin
        st_d = st_q;
        st_d.prev = source;
        st_d.event_hit = 1'b0;
        if (setup.enable) begin
            case (setup.mode)
                IRQ_LOW_LEVEL: st_d.event_hit = ~source;
                IRQ_HIGH_LEVEL: st_d.event_hit = source;
                IRQ_FALL_EDGE: st_d.event_hit = st_q.prev & ~source;
                IRQ_RISE_EDGE: st_d.event_hit = ~st_q.prev & source;
                default: st_d.event_hit = 1'b0;
            endcase
        end
    end

    // Idle line sits high behind the pull-ups, so prev starts high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= 2'b10;
        end else begin
            st_q <= st_d;
        end
    end

    assign event_out = st_q.event_hit;

endmodule

// File: design/dual_bank_parallel_io.sv
`timescale 1ns/1ps

// What this block does
// - An input bit reads one when its pin is high, zero when low.
// - An undriven input line reads one through the board pull-ups.
// - Reading an output port returns its output register, the driven value.
// - Each port keeps an output register, always writable, kept across turns.
// - Outputs are active high: stored one drives high, zero drives low.
// - Port C is read and written as one eight-bit register.
// - Split port C reads live pins on input nibble, outputs on other.
// - Split port C write drives output nibble, only stores input nibble.
// - Registers sit at base plus offset; bank one 0 to 6, bank two 8 up.
// - Port and nibble directions are set through the write-only control word.
// - Interrupt setup holds enable in bit 2, mode in bits 1:0, rest zero.
// - A control word command sets or clears one port C bit alone.
// - Direction bits: 0 C low, 1 B, 3 C high, 4 A; one is input.
// - Mode 00 low, 01 high, 10 falling, 11 rising on source line.
// - Each bank's interrupt source is its port A bit 0; enables reset zero.
// - Pending bank one in bit 0, bank two in bit 4; read clears.
module dual_bank_parallel_io
    import parallel_io_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [AXI_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [AXI_DATA_W-1:0] wdata,
    input wire logic [AXI_DATA_W/8-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [AXI_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Port pins of both banks
    input wire port_bytes_t [NUM_BANKS-1:0] pin_in,
    output port_bytes_t [NUM_BANKS-1:0] pin_out,
    output port_bytes_t [NUM_BANKS-1:0] pin_oe,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // All state of the block apart from the trigger detectors
    typedef struct packed {
        logic aw_held;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [AXI_DATA_W-1:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [AXI_DATA_W-1:0] rdata;
        port_bytes_t [NUM_BANKS-1:0] out_reg;
        port_bytes_t [NUM_BANKS-1:0] oe;
        dir_t [NUM_BANKS-1:0] dir;
        irq_setup_t [NUM_BANKS-1:0] irq_setup;
        logic [NUM_BANKS-1:0] pending;
        logic [NUM_BANKS-1:0] mask;
        logic irq;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic [NUM_BANKS-1:0] trig_event;

    ////////////////////////////////////////////////////////////////////////
    // Address decode: index to bank and register kind
    function automatic reg_loc_t decode_loc(
        input logic [REG_IDX_W-1:0] idx
    );
        reg_loc_t loc;
        loc = LOC_NONE;
        if (idx == IDX_B1_PORT_A || idx == IDX_B2_PORT_A) begin
            loc = LOC_PORT_A;
        end else if (idx == IDX_B1_PORT_B || idx == IDX_B2_PORT_B) begin
            loc = LOC_PORT_B;
        end else if (idx == IDX_B1_PORT_C || idx == IDX_B2_PORT_C) begin
            loc = LOC_PORT_C;
        end else if (idx == IDX_B1_DIR_CTRL || idx == IDX_B2_DIR_CTRL) begin
            loc = LOC_DIR_CTRL;
        end else if (idx == IDX_B1_IRQ_SETUP || idx == IDX_B2_IRQ_SETUP) begin
            loc = LOC_IRQ_SETUP;
        end else if (idx == IDX_IRQ_PENDING) begin
            loc = LOC_PENDING;
        end else if (idx == IDX_IRQ_MASK) begin
            loc = LOC_MASK;
        end else begin
            loc = LOC_NONE;
        end
        return loc;
    endfunction

    // Bank two registers lie eight indices above bank one
    function automatic logic decode_bank(
        input logic [REG_IDX_W-1:0] idx
    );
        return (idx >= IDX_B2_PORT_A) ? 1'b1 : 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-bit readback: input bits show the pins, output bits the register
    function automatic port_bytes_t port_view(
        input port_bytes_t pins,
        input port_bytes_t outs,
        input dir_t dir
    );
        port_bytes_t v;
        v.a = dir.a ? pins.a : outs.a;
        v.b = dir.b ? pins.b : outs.b;
        // Nibbles pick their sources apart when the port is split
        v.c[NIBBLE_W-1:0] = dir.c_lo ? pins.c[NIBBLE_W-1:0]
                                     : outs.c[NIBBLE_W-1:0];
        v.c[BYTE_W-1:NIBBLE_W] = dir.c_hi ? pins.c[BYTE_W-1:NIBBLE_W]
                                          : outs.c[BYTE_W-1:NIBBLE_W];
        return v;
    endfunction

    // Pending flags laid out at their status bit positions
    function automatic logic [BYTE_W-1:0] flag_layout(
        input logic [NUM_BANKS-1:0] flags
    );
        logic [BYTE_W-1:0] v;
        v = 8'h00;
        v[PEND_BANK1_BIT] = flags[0];
        v[PEND_BANK2_BIT] = flags[1];
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Trigger detectors, one per bank, sensing port A bit 0
    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_trig
        irq_trigger u_trig (
            .aclk(aclk),
            .aresetn(aresetn),
            .setup(st_q.irq_setup[g]),
            .source(pin_in[g].a[IRQ_SRC_BIT]),
            .event_out(trig_event[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        reg_loc_t wloc;
        reg_loc_t rloc;
        logic wbank;
        logic rbank;
        logic do_write;
        logic do_read;
        logic [REG_IDX_W-1:0] widx;
        logic [REG_IDX_W-1:0] ridx;
        logic [BYTE_W-1:0] wbyte;
        logic [BSR_SEL_MSB-BSR_SEL_LSB:0] bsr_sel;
        logic [BYTE_W-1:0] rbyte;
        port_bytes_t view;

        st_d = st_q;
        widx = st_q.aw_addr[AXI_ADDR_W-1:2];
        ridx = araddr[AXI_ADDR_W-1:2];
        wloc = decode_loc(widx);
        rloc = decode_loc(ridx);
        wbank = decode_bank(widx);
        rbank = decode_bank(ridx);
        wbyte = st_q.w_data[BYTE_W-1:0];
        bsr_sel = wbyte[BSR_SEL_MSB:BSR_SEL_LSB];
        rbyte = 8'h00;
        view = port_view(pin_in[rbank], st_q.out_reg[rbank],
                         st_q.dir[rbank]);

        // Address and data are caught in either order
        if (awvalid && st_q.awready) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = awaddr;
        end
        if (wvalid && st_q.wready) begin
            st_d.w_held = 1'b1;
            st_d.w_data = wdata;
            st_d.w_lane0 = wstrb[0];
        end
        if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end

        // Write executes once both halves are held and no answer waits
        do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;
        if (do_write) begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = (wloc == LOC_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (st_q.w_lane0) begin
                case (wloc)
                    LOC_PORT_A: st_d.out_reg[wbank].a = wbyte;
                    LOC_PORT_B: st_d.out_reg[wbank].b = wbyte;
                    // Whole byte lands in the register; input nibble pins
                    // stay undriven since their enables are off
                    LOC_PORT_C: st_d.out_reg[wbank].c = wbyte;
                    LOC_DIR_CTRL: begin
                        if (wbyte[CMD_SELECT_BIT]) begin
                            st_d.dir[wbank].a = wbyte[DIR_A_BIT];
                            st_d.dir[wbank].b = wbyte[DIR_B_BIT];
                            st_d.dir[wbank].c_hi = wbyte[DIR_C_HI_BIT];
                            st_d.dir[wbank].c_lo = wbyte[DIR_C_LO_BIT];
                        end else begin
                            st_d.out_reg[wbank].c[bsr_sel] =
                                wbyte[BSR_VALUE_BIT];
                        end
                    end
                    LOC_IRQ_SETUP:
                        st_d.irq_setup[wbank] = wbyte[IRQ_SETUP_W-1:0];
                    LOC_PENDING: begin
                        // Writing a one also clears, for polled use
                        if (wbyte[PEND_BANK1_BIT]) begin
                            st_d.pending[0] = 1'b0;
                        end
                        if (wbyte[PEND_BANK2_BIT]) begin
                            st_d.pending[1] = 1'b0;
                        end
                    end
                    LOC_MASK: begin
                        st_d.mask[0] = wbyte[PEND_BANK1_BIT];
                        st_d.mask[1] = wbyte[PEND_BANK2_BIT];
                    end
                    default: st_d.bresp = RESP_SLVERR;
                endcase
            end
        end

        // Read answer retires when the master takes it
        if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
        do_read = arvalid && st_q.arready;
        if (do_read) begin
            case (rloc)
                LOC_PORT_A: rbyte = view.a;
                LOC_PORT_B: rbyte = view.b;
                LOC_PORT_C: rbyte = view.c;
                LOC_DIR_CTRL: rbyte = 8'h00; // Write-only
                LOC_IRQ_SETUP: rbyte = {5'h00, st_q.irq_setup[rbank]};
                LOC_PENDING: begin
                    rbyte = flag_layout(st_q.pending);
                    st_d.pending = '0;
                end
                LOC_MASK: rbyte = flag_layout(st_q.mask);
                default: rbyte = 8'h00;
            endcase
            st_d.rvalid = 1'b1;
            st_d.rdata = {24'h000000, rbyte};
            st_d.rresp = (rloc == LOC_NONE) ? RESP_SLVERR : RESP_OKAY;
        end

        // Events come last so a trigger in the clearing cycle survives
        st_d.pending = st_d.pending | trig_event;

        // Ready flags follow the hold state, one item of each in flight
        st_d.awready = !st_d.aw_held && !st_d.bvalid;
        st_d.wready = !st_d.w_held && !st_d.bvalid;
        st_d.arready = !st_d.rvalid;

        // Enables follow directions; register keeps value across turns
        for (int b = 0; b < NUM_BANKS; b++) begin
            st_d.oe[b].a = {BYTE_W{~st_d.dir[b].a}};
            st_d.oe[b].b = {BYTE_W{~st_d.dir[b].b}};
            st_d.oe[b].c = {{NIBBLE_W{~st_d.dir[b].c_hi}},
                            {NIBBLE_W{~st_d.dir[b].c_lo}}};
        end

        // Single level line for any unmasked pending flag
        st_d.irq = |(st_d.pending & st_d.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; all ports come up as inputs, interrupts off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q.aw_held <= 1'b0;
            st_q.aw_addr <= 8'h00;
            st_q.w_held <= 1'b0;
            st_q.w_data <= 32'h00000000;
            st_q.w_lane0 <= 1'b0;
            st_q.awready <= 1'b0;
            st_q.wready <= 1'b0;
            st_q.bvalid <= 1'b0;
            st_q.bresp <= RESP_OKAY;
            st_q.arready <= 1'b0;
            st_q.rvalid <= 1'b0;
            st_q.rresp <= RESP_OKAY;
            st_q.rdata <= 32'h00000000;
            st_q.out_reg <= {NUM_BANKS{OUT_RESET}};
            st_q.oe <= {NUM_BANKS{OE_RESET}};
            st_q.dir <= {NUM_BANKS{DIR_RESET}};
            st_q.irq_setup <= {NUM_BANKS{IRQ_SETUP_RESET}};
            st_q.pending <= 2'h0;
            st_q.mask <= 2'h0;
            st_q.irq <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign awready = st_q.awready;
    assign wready = st_q.wready;
    assign bvalid = st_q.bvalid;
    assign bresp = st_q.bresp;
    assign arready = st_q.arready;
    assign rvalid = st_q.rvalid;
    assign rresp = st_q.rresp;
    assign rdata = st_q.rdata;
    assign pin_out = st_q.out_reg;
    assign pin_oe = st_q.oe;
    assign irq = st_q.irq;

endmodule

// File: testbench/dual_bank_parallel_io_props.sv
`timescale 1ns/1ps

module bank_checker
    import parallel_io_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [AXI_DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // Pins and interrupt
    input wire port_bytes_t [NUM_BANKS-1:0] pin_out,
    input wire port_bytes_t [NUM_BANKS-1:0] pin_oe,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // Bus timing as handed over
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    write_answer_a: assert property (awvalid && awready && wvalid && wready
        |-> ##2 bvalid) else $error("write answer late");
    read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    busy_ready_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answering");
    // Registers are one byte wide; refused reads carry nothing
    byte_wide_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    refused_zero_a: assert property (rvalid && rresp == RESP_SLVERR
        |-> rdata == 32'h0) else $error("refused read data");
    // Direction is per port and per nibble, never per bit
    whole_port_a: assert property ((&pin_oe[0].a == |pin_oe[0].a)
        && (&pin_oe[1].b == |pin_oe[1].b)) else $error("port split");
    nibble_dir_a: assert property ((&pin_oe[1].c[3:0] == |pin_oe[1].c[3:0])
        && (&pin_oe[1].c[7:4] == |pin_oe[1].c[7:4])) else $error("bad nibble");
    // Pins move only in the cycle that a write executes and answers
    dir_on_write_a: assert property ($changed(pin_oe) |-> $rose(bvalid))
        else $error("direction moved without write");
    out_on_write_a: assert property ($changed(pin_out) |-> $rose(bvalid))
        else $error("output moved without write");

    cover property (bvalid && bresp == RESP_SLVERR);
    cover property ($rose(irq));
    cover property (pin_oe[1].c == 8'h0F);
endmodule

bind dual_bank_parallel_io bank_checker chk_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_out(pin_out), .pin_oe(pin_oe),
    .irq(irq)
);

// File: testbench/ext_lines.sv
`timescale 1ns/1ps

module ext_lines
    import parallel_io_pkg::*;
(
    // Device side of the pins
    input wire port_bytes_t [NUM_BANKS-1:0] pin_out,
    input wire port_bytes_t [NUM_BANKS-1:0] pin_oe,
    // Far-side drivers
    input wire port_bytes_t [NUM_BANKS-1:0] ext_en,
    input wire port_bytes_t [NUM_BANKS-1:0] ext_val,
    // Resolved line levels
    output port_bytes_t [NUM_BANKS-1:0] pin_in
);
    // Device drive wins; an undriven line floats up to the pull-up
    assign pin_in = (pin_oe & pin_out)
        | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en);
endmodule

// File: testbench/dual_bank_parallel_io_test.sv
`timescale 1ns/1ps

module dual_bank_parallel_io_test import parallel_io_pkg::*;;
    logic aclk = '0;
    logic aresetn = '0;
    logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [AXI_DATA_W-1:0] wdata = '0;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [AXI_DATA_W-1:0] rdata;
    port_bytes_t [NUM_BANKS-1:0] pin_in, pin_out, pin_oe;
    port_bytes_t [NUM_BANKS-1:0] ext_en = '0, ext_val = '0;
    int mismatches = 0, num_checks = 0, cyc = 0;

    always #50 aclk = ~aclk;

    dual_bank_parallel_io uut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

    ext_lines far_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the end of the run or the watchdog
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // Bus cycles; every wait is cut short by the watchdog only
    task automatic wr(input logic [5:0] i, input logic [7:0] d,
            input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (awvalid || wvalid);
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] e,
            input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
        chk(rdata, {24'h0, e});
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        chk({8'h0, pin_oe[0] | pin_oe[1]}, 32'h0);
        rd(IDX_B1_PORT_A, 8'hFF);
        rd(IDX_B2_PORT_C, 8'hFF);
        rd(IDX_B1_IRQ_SETUP, 8'h00);
        rd(IDX_B2_IRQ_SETUP, 8'h00);
        rd(IDX_IRQ_PENDING, 8'h00);
    endtask

    task automatic t_inputs;
        ext_en[0].a <= 8'hFF;
        ext_val[0].a <= 8'h6C;
        ext_en[1].b <= 8'hFF;
        ext_val[1].b <= 8'h93;
        rd(IDX_B1_PORT_A, 8'h6C);
        rd(IDX_B2_PORT_B, 8'h93);
        rd(6'h07, 8'h00, RESP_SLVERR);
        wr(6'h0F, 8'h55, RESP_SLVERR);
        rd(IDX_B1_DIR_CTRL, 8'h00);
    endtask

    // Preset while input, then turn; value survives turning back and forth
    task automatic t_preset;
        wr(IDX_B1_PORT_B, 8'h5A);
        rd(IDX_B1_PORT_B, 8'hFF);
        wr(IDX_B1_DIR_CTRL, 8'h99);
        chk({24'h0, pin_oe[0].b}, 32'hFF);
        chk({24'h0, pin_in[0].b}, 32'h5A);
        rd(IDX_B1_PORT_B, 8'h5A);
        wr(IDX_B1_PORT_B, 8'hC3);
        rd(IDX_B1_PORT_B, 8'hC3);
        wr(IDX_B1_DIR_CTRL, 8'h9B);
        rd(IDX_B1_PORT_B, 8'hFF);
        wr(IDX_B1_DIR_CTRL, 8'h99);
        rd(IDX_B1_PORT_B, 8'hC3);
    endtask

    task automatic t_split;
        ext_en[1].c <= 8'hF0;
        ext_val[1].c <= 8'h3C;
        wr(IDX_B2_DIR_CTRL, 8'h9A);
        wr(IDX_B2_PORT_C, 8'hA5);
        @(posedge aclk);
        chk({24'h0, pin_oe[1].c}, 32'h0F);
        chk({24'h0, pin_out[1].c}, 32'hA5);
        chk({24'h0, pin_in[1].c}, 32'h35);
        rd(IDX_B2_PORT_C, 8'h35);
    endtask

    task automatic t_bitcmd;
        wr(IDX_B1_DIR_CTRL, 8'h92);
        wr(IDX_B1_PORT_C, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(IDX_B1_DIR_CTRL, {4'h0, 3'(k), 1'h1});
            rd(IDX_B1_PORT_C, 8'hFF >> (7 - k));
        end
        wr(IDX_B1_DIR_CTRL, 8'h06);
        rd(IDX_B1_PORT_C, 8'hF7);
        chk({24'h0, pin_oe[0].c}, 32'hFF);
        chk({24'h0, pin_in[0].c}, 32'hF7);
    endtask

    // Every trigger mode on bank one; the level returns idle before the read
    task automatic t_irq;
        wr(IDX_IRQ_MASK, 8'h11);
        for (int m = 0; m < 4; m++) begin
            ext_val[0].a[0] <= ~m[0];
            wr(IDX_B1_IRQ_SETUP, {5'h0, 1'h1, 2'(m)});
            wr(IDX_IRQ_PENDING, 8'h11);
            repeat (2) @(posedge aclk);
            chk({31'h0, irq}, 32'h0);
            ext_val[0].a[0] <= m[0];
            repeat (4) @(posedge aclk);
            chk({31'h0, irq}, 32'h1);
            ext_val[0].a[0] <= ~m[0];
            repeat (4) @(posedge aclk);
            rd(IDX_IRQ_PENDING, 8'h01);
            repeat (2) @(posedge aclk);
            chk({31'h0, irq}, 32'h0);
        end
        rd(IDX_B1_IRQ_SETUP, 8'h07);
        wr(IDX_B1_IRQ_SETUP, 8'hF8);
        rd(IDX_B1_IRQ_SETUP, 8'h00);
    endtask

    // Bank two masked: pending still latches, the output stays quiet
    task automatic t_mask;
        ext_en[1].a <= 8'h01;
        ext_val[1].a <= 8'h00;
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_B2_IRQ_SETUP, 8'h07);
        wr(IDX_IRQ_PENDING, 8'h11);
        ext_val[1].a[0] <= 1'h1;
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd(IDX_IRQ_PENDING, 8'h10);
        rd(IDX_IRQ_PENDING, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        t_reset;
        t_inputs;
        t_preset;
        t_split;
        t_bitcmd;
        t_irq;
        t_mask;
        close_out;
    end

    // Watchdog; the whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            close_out;
        end
    end
endmodule
